// >>> hdl/cell_overvoltage_monitor_regs.sv
// Limit configuration and overvoltage flag registers of the cell monitor
`timescale 1ns/1ps
`default_nettype none
module cell_overvoltage_monitor_regs (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_WR_EN,
  input wire logic I_RD_EN,
  input wire logic [cell_limit_pkg::ADDR_WIDTH-1:0] I_ADDR,
  input wire logic [cell_limit_pkg::REG_WIDTH-1:0] I_WDATA,
  input wire logic I_NORMAL_MODE,
  input wire logic I_CONV_DONE,
  input wire logic [cell_limit_pkg::NUM_CELLS-1:0] I_CELL_OVER,
  output logic [cell_limit_pkg::REG_WIDTH-1:0] O_RDATA,
  output logic O_RVALID,
  output logic O_SHARED_HIGH_LIMIT_SELECT,
  output logic O_SHARED_LOW_LIMIT_SELECT,
  output logic [cell_limit_pkg::NUM_CELLS-1:0] O_CELL_LIMIT_CHECK_ENABLE,
  output logic [cell_limit_pkg::NUM_CELLS-1:0] O_CELL_HIGH_VOLTAGE_FLAG
);
  import cell_limit_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [REG_WIDTH-1:0] config_q, config_d;
  logic [NUM_CELLS-1:0] flags_q, flags_d;
  logic [REG_WIDTH-1:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [NUM_CELLS-1:0] detect;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Shared by the write and read paths so both decode one way
  function automatic logic addr_is(input logic [ADDR_WIDTH-1:0] a, input logic [ADDR_WIDTH-1:0] t);
    return (a == t);
  endfunction

  // Detection only on enabled terminals, sampled on conversion end
  assign detect = I_CONV_DONE ? (I_CELL_OVER & config_q[NUM_CELLS-1:0]) : '0;

  // Next state: config write, flag zero-write clear with set winning
  always_comb begin
    config_d = config_q;
    flags_d = flags_q;
    if (I_WR_EN && addr_is(I_ADDR, CONFIG_ADDR)) begin
      config_d = I_WDATA;
    end
    // Outside normal mode the host cannot wipe a pending fault
    if (I_WR_EN && addr_is(I_ADDR, FLAGS_ADDR) && I_NORMAL_MODE) begin
      flags_d = flags_q & I_WDATA[NUM_CELLS-1:0];
    end
    flags_d = flags_d | detect;
  end

  // Read port, top two flag bits read as zero
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = I_RD_EN;
    if (I_RD_EN) begin
      if (addr_is(I_ADDR, CONFIG_ADDR)) begin
        rdata_d = config_q;
      end else if (addr_is(I_ADDR, FLAGS_ADDR)) begin
        rdata_d = {2'h0, flags_q};
      end else begin
        rdata_d = 16'h0000;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      config_q <= CONFIG_RESET;
      flags_q <= FLAGS_RESET[NUM_CELLS-1:0];
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      O_SHARED_HIGH_LIMIT_SELECT <= 1'b0;
      O_SHARED_LOW_LIMIT_SELECT <= 1'b0;
      O_CELL_LIMIT_CHECK_ENABLE <= CONFIG_RESET[NUM_CELLS-1:0];
      O_CELL_HIGH_VOLTAGE_FLAG <= '0;
    end else begin
      config_q <= config_d;
      flags_q <= flags_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      O_SHARED_HIGH_LIMIT_SELECT <= config_d[HIGH_SEL_BIT];
      O_SHARED_LOW_LIMIT_SELECT <= config_d[LOW_SEL_BIT];
      O_CELL_LIMIT_CHECK_ENABLE <= config_d[NUM_CELLS-1:0];
      O_CELL_HIGH_VOLTAGE_FLAG <= flags_d;
    end
  end

  assign O_RDATA = rdata_q;
  assign O_RVALID = rvalid_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_set_on_conv;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (I_CONV_DONE && I_CELL_OVER[0] && config_q[0]) |=> flags_q[0];
  endproperty
  a_set_on_conv: assert property (p_set_on_conv) else $error("flag not set on conversion");

  property p_disabled_no_set;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (!flags_q[0] && !config_q[0] && !(I_WR_EN && I_ADDR == FLAGS_ADDR)) |=> !flags_q[0];
  endproperty
  a_disabled_no_set: assert property (p_disabled_no_set) else $error("disabled cell raised flag");

  property p_top_zero;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (I_RD_EN && I_ADDR == FLAGS_ADDR) |=> (O_RDATA[15:14] == 2'h0 && O_RDATA[13:0] == $past(flags_q));
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("flag read wrong");

  property p_clear_zero;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (I_WR_EN && I_ADDR == FLAGS_ADDR && I_NORMAL_MODE && !I_WDATA[1] && !detect[1]) |=> !flags_q[1];
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("zero write did not clear");

  property p_one_keeps;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (I_WR_EN && I_ADDR == FLAGS_ADDR && I_WDATA[2] && !detect[2]) |=> (flags_q[2] == $past(flags_q[2]));
  endproperty
  a_one_keeps: assert property (p_one_keeps) else $error("one write changed flag");

  property p_sel_out;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (I_WR_EN && I_ADDR == CONFIG_ADDR) |=> (O_SHARED_HIGH_LIMIT_SELECT == $past(I_WDATA[15])
        && O_SHARED_LOW_LIMIT_SELECT == $past(I_WDATA[14]));
  endproperty
  a_sel_out: assert property (p_sel_out) else $error("select bits wrong");

  property p_flag_out;
    @(posedge I_CLK) disable iff (I_SYS_RST) O_CELL_HIGH_VOLTAGE_FLAG == flags_q;
  endproperty
  a_flag_out: assert property (p_flag_out) else $error("flag output mismatch");

  property p_set_wins;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (detect[3] && I_WR_EN && I_ADDR == FLAGS_ADDR && !I_WDATA[3]) |=> flags_q[3];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");

  // ----------------------------------------
  // Host side answer checks
  // ----------------------------------------
  // A read strobe taken on the edge
  sequence s_read_taken;
    I_RD_EN;
  endsequence

  // The answer strobe one cycle later
  sequence s_read_answer;
    ##1 O_RVALID;
  endsequence

  // Every read is answered exactly one cycle later
  property p_rvalid_pulse;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      s_read_taken |-> s_read_answer;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer missing");

  // No answer strobe without a read
  property p_rvalid_single;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (!I_RD_EN) |=> !O_RVALID;
  endproperty
  a_rvalid_single: assert property (p_rvalid_single) else $error("spurious read answer");

  // A read of an unmapped place
  sequence s_unmapped_read;
    I_RD_EN && !addr_is(I_ADDR, CONFIG_ADDR) && !addr_is(I_ADDR, FLAGS_ADDR);
  endsequence

  // Unmapped places read back as zero
  property p_unmapped_zero;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      s_unmapped_read |=> (O_RDATA == 16'h0000);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  // Config read returns the stored word
  property p_config_read;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (I_RD_EN && addr_is(I_ADDR, CONFIG_ADDR)) |=> (O_RDATA == $past(config_q));
  endproperty
  a_config_read: assert property (p_config_read) else $error("config read wrong");

  // ----------------------------------------
  // Flag and enable checks
  // ----------------------------------------
  // Flag writes outside normal mode change nothing
  property p_mode_refused;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (I_WR_EN && addr_is(I_ADDR, FLAGS_ADDR) && !I_NORMAL_MODE && detect == '0)
        |=> (flags_q == $past(flags_q));
  endproperty
  a_mode_refused: assert property (p_mode_refused) else $error("flag write honoured outside normal mode");

  // Without a conversion a clear flag stays clear
  property p_no_conv_no_set;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (!I_CONV_DONE && !flags_q[4]) |=> !flags_q[4];
  endproperty
  a_no_conv_no_set: assert property (p_no_conv_no_set) else $error("flag set without conversion");

  // Enable outputs follow a config write one cycle later
  property p_enable_out;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (I_WR_EN && addr_is(I_ADDR, CONFIG_ADDR)) |=> (O_CELL_LIMIT_CHECK_ENABLE == $past(I_WDATA[13:0]));
  endproperty
  a_enable_out: assert property (p_enable_out) else $error("enable outputs wrong");
endmodule // cell_overvoltage_monitor_regs
`default_nettype wire

// >>> hdl/cell_limit_pkg.sv
// Constants for the cell voltage limit supervision register bank
// Summary of operation
// - Config bit 15 picks shared high limit, bit 14 shared low limit.
// - Flag register holds terminal 14 at bit 13 to terminal 1 at bit 0; top bits zero.
// - Flags update after every cyclic and every on-demand conversion.
// - A flag reads 1 when overvoltage was detected on that terminal.
// - In normal mode host clears a flag by writing 0 once condition is gone.
// - Reset clears the flags; a zero write clears them in normal mode only.
// - Only enabled terminals are compared; disabled terminals raise no fault.
package cell_limit_pkg;
  localparam int NUM_CELLS = 14;
  localparam int REG_WIDTH = 16;
  localparam int ADDR_WIDTH = 7;
  localparam logic [6:0] CONFIG_ADDR = 7'h08;
  localparam logic [6:0] FLAGS_ADDR = 7'h09;
  localparam int HIGH_SEL_BIT = 15;
  localparam int LOW_SEL_BIT = 14;
  localparam logic [15:0] CONFIG_RESET = 16'h3FFF;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
endpackage

// >>> verif/tb.sv
// Self-checking bench for the cell limit register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cell_limit_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, nm = 1'b1, cv = 1'b0;
  logic [6:0] ad = 7'h00;
  logic [15:0] wd = 16'h0000, rdat;
  logic [13:0] ov = 14'h0000, en, fl;
  logic rv, hs, ls;
  int n_errors = 0, samples_checked = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  cell_overvoltage_monitor_regs u_cell_overvoltage_monitor_regs (.I_CLK(clk), .I_SYS_RST(rst), .I_WR_EN(wr),
    .I_RD_EN(rd), .I_ADDR(ad), .I_WDATA(wd), .I_NORMAL_MODE(nm), .I_CONV_DONE(cv), .I_CELL_OVER(ov),
    .O_RDATA(rdat), .O_RVALID(rv), .O_SHARED_HIGH_LIMIT_SELECT(hs), .O_SHARED_LOW_LIMIT_SELECT(ls),
    .O_CELL_LIMIT_CHECK_ENABLE(en), .O_CELL_HIGH_VOLTAGE_FLAG(fl));
  // ------------------------------------------
  // Host access tasks, driven on falling edges
  // ------------------------------------------
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrt(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk);
    wr = 1'b1;
    ad = a;
    wd = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // Read data lands one cycle after the strobe
  task automatic rdc(input logic [6:0] a, input logic [15:0] e);
    @(negedge clk);
    rd = 1'b1;
    ad = a;
    @(negedge clk);
    rd = 1'b0;
    chk({15'h0000, rv}, 16'h0001);
    chk(rdat, e);
  endtask
  // One conversion result, pulsed for a single cycle
  task automatic conv(input logic [13:0] v);
    @(negedge clk);
    cv = 1'b1;
    ov = v;
    @(negedge clk);
    cv = 1'b0;
    ov = 14'h0000;
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rdc(CONFIG_ADDR, CONFIG_RESET);
    rdc(FLAGS_ADDR, FLAGS_RESET);
    rdc(7'h0A, 16'h0000); // Unmapped place reads zero
    $display("test reset done");
    // All four limit source codes
    for (int i = 0; i < 4; i++) begin
      wrt(CONFIG_ADDR, {i[1:0], 14'h2005});
      chk({hs, ls, en}, {i[1:0], 14'h2005});
    end
    rdc(CONFIG_ADDR, 16'hE005);
    $display("test config done");
    // Only enabled terminals 14, 3 and 1 may latch
    conv(14'h3FFF);
    chk({2'b00, fl}, 16'h2005);
    wrt(FLAGS_ADDR, 16'hFFFF);
    chk({2'b00, fl}, 16'h2005);
    nm = 1'b0;
    wrt(FLAGS_ADDR, 16'h0000);
    chk({2'b00, fl}, 16'h2005);
    nm = 1'b1;
    wrt(FLAGS_ADDR, 16'hFFFE);
    chk({2'b00, fl}, 16'h2004);
    wrt(CONFIG_ADDR, 16'h0000);
    conv(14'h3FFF);
    rdc(FLAGS_ADDR, 16'h2004);
    $display("test flags done");
    // Conversion and zero write in one cycle: set wins
    wrt(CONFIG_ADDR, 16'h3FFF);
    @(negedge clk);
    cv = 1'b1;
    ov = 14'h000A;
    wr = 1'b1;
    ad = FLAGS_ADDR;
    wd = 16'h0000;
    @(negedge clk);
    cv = 1'b0;
    ov = 14'h0000;
    wr = 1'b0;
    chk({2'b00, fl}, 16'h000A);
    wrt(FLAGS_ADDR, 16'h0000);
    chk({2'b00, fl}, 16'h0000);
    $display("test set wins done");
    stop_test();
  end
  // Watchdog: the tests need far less than this
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
endmodule // tb
`default_nettype wire
